// >>> rtl/pio_pkg.sv
package pio_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
  localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
  localparam logic [7:0] ADDR_PORT2_LATCH = 8'hA0;
  localparam logic [7:0] ADDR_PORT3_LATCH = 8'hB0;
  localparam logic [7:0] ADDR_PORT0_DRIVE = 8'hA4;
  localparam logic [7:0] ADDR_PORT1_DRIVE = 8'hA5;
  localparam logic [7:0] ADDR_PORT2_DRIVE = 8'hA6;
  localparam logic [7:0] ADDR_PORT3_DRIVE = 8'hA7;
  localparam logic [7:0] ADDR_PORT0_BYPASS = 8'hD4;
  localparam logic [7:0] ADDR_PORT1_BYPASS = 8'hD5;
  localparam logic [7:0] ADDR_PORT2_BYPASS = 8'hD6;
  localparam logic [7:0] ADDR_PORT3_BYPASS = 8'hDF;
  localparam logic [7:0] ADDR_ROUTING_THIRD = 8'hE3;
  localparam logic [7:0] ADDR_PORT0_ANALOG = 8'hF1;
  localparam logic [7:0] ADDR_PORT1_ANALOG = 8'hF2;
  localparam logic [7:0] ADDR_PORT2_ANALOG = 8'hF3;
  localparam logic [7:0] ADDR_PORT3_ANALOG = 8'hF4;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int UART_ROUTE_BIT = 0;
  localparam int BIT_SEL_W = 3;
  localparam int NUM_PORTS = 4;
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [7:0] INPUT_MODE_RESET = 8'hFF;
  localparam logic [7:0] DRIVE_TYPE_RESET = 8'h00;
  localparam logic [7:0] BYPASS_RESET = 8'h00;
  localparam logic [7:0] ROUTING_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  localparam logic [7:0] PORT3_SMALL_MASK = 8'h01;
  localparam logic [7:0] PORT3_FULL_MASK = 8'hFF;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bit_mode;
    logic rmw;
  } pio_sfr_req_t;

  typedef struct packed {
    logic [7:0] assigned;
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] open_drain;
  } pio_xbar_pin_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pullup_en;
    logic [7:0] rx_en;
  } pio_pin_ctl_t;

  typedef struct packed {
    logic [NUM_PORTS-1:0][7:0] latch;
    logic [NUM_PORTS-1:0][7:0] input_mode;
    logic [NUM_PORTS-1:0][7:0] drive_type;
    logic [NUM_PORTS-1:0][7:0] bypass;
    logic second_uart_route_en;
    logic [NUM_PORTS-1:0][7:0] sync1;
    logic [NUM_PORTS-1:0][7:0] sync2;
    logic [7:0] rdata;
  } pio_state_t;

endpackage

// >>> rtl/pio_port_block.sv
// Function
// (RULE1) software writes zero to reserved bits 7..1 of third routing reg
// (RULE2) routing bit 0 set routes second uart transmit and receive to pins
// (RULE3) unassigned non-analog pins act as gpio under port registers
// (RULE4) port 0..3 latches take byte and single-bit accesses
// (RULE5) written latch value stored and keeps driving pin data
// (RULE6) ordinary port read returns pin levels, even crossbar-assigned pins
// (RULE7) read-modify-write reads return latch contents instead of pins
// (RULE8) ports 0..2 reach pins per crossbar routing, only when enabled
// (RULE9) latch zero drives low; one drives high push-pull, else released
// (RULE10) analog input pin reads zero; digital pin read directly
// (RULE11) input mode zero is analog: pull-up, driver, receiver disabled
// (RULE12) input mode one is digital; input mode regs reset to ones
// (RULE13) drive type zero open-drain, one push-pull; resets to zeros
// (RULE14) drive type ignored while the pin is analog
// (RULE15) smbus data or clock pins are always open-drain
// (RULE16) bypass bit one makes crossbar skip pin; bypass resets to zero
// (RULE17) software sets bypass on analog and special-function pins
// (RULE18) port 3 latch drives pins subject to drive and input mode
// (RULE19) port 3 bits 1..7 removable by parameter for small packages
// (RULE20) crossbar disabled means all port 0..3 drivers off
// (RULE21) weak pull-up on open-drain digital pins unless disabled
// (RULE22) weak pull-up off on any pin driving low
// (RULE23) single-bit latch write changes only the addressed bit
// (RULE24) all latches reset to ones
module pio_port_block #(
  parameter bit PORT3_FULL = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // special function register bus
  input wire pio_pkg::pio_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // crossbar controls from the routing registers outside
  input wire logic crossbar_global_en,
  input wire logic weak_pullup_disable,
  // crossbar decoder
  input wire pio_pkg::pio_xbar_pin_t [3:0] xbar_pin,
  output logic [3:0][7:0] crossbar_bypass_mask,
  output logic second_uart_route_en,
  // pins
  input wire logic [3:0][7:0] pin_in,
  output pio_pkg::pio_pin_ctl_t [3:0] pin_ctl,
  output logic [3:0][7:0] pin_level
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT3_MASK =
    PORT3_FULL ? pio_pkg::PORT3_FULL_MASK : pio_pkg::PORT3_SMALL_MASK;

  localparam pio_pkg::pio_state_t RESET_STATE = '{
    latch: {pio_pkg::NUM_PORTS{pio_pkg::LATCH_RESET}},
    input_mode: {pio_pkg::NUM_PORTS{pio_pkg::INPUT_MODE_RESET}},
    drive_type: {pio_pkg::NUM_PORTS{pio_pkg::DRIVE_TYPE_RESET}},
    bypass: {pio_pkg::NUM_PORTS{pio_pkg::BYPASS_RESET}},
    second_uart_route_en: pio_pkg::ROUTING_RESET[pio_pkg::UART_ROUTE_BIT],
    sync1: {pio_pkg::NUM_PORTS{8'h00}},
    sync2: {pio_pkg::NUM_PORTS{8'h00}},
    rdata: pio_pkg::READ_NONE
  };

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] latch_port(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h4;
    case (addr)
      pio_pkg::ADDR_PORT0_LATCH: sel = 3'h0;
      pio_pkg::ADDR_PORT1_LATCH: sel = 3'h1;
      pio_pkg::ADDR_PORT2_LATCH: sel = 3'h2;
      pio_pkg::ADDR_PORT3_LATCH: sel = 3'h3;
      default: sel = 3'h4;
    endcase
    return sel;
  endfunction

  function automatic logic [2:0] drive_port(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h4;
    case (addr)
      pio_pkg::ADDR_PORT0_DRIVE: sel = 3'h0;
      pio_pkg::ADDR_PORT1_DRIVE: sel = 3'h1;
      pio_pkg::ADDR_PORT2_DRIVE: sel = 3'h2;
      pio_pkg::ADDR_PORT3_DRIVE: sel = 3'h3;
      default: sel = 3'h4;
    endcase
    return sel;
  endfunction

  function automatic logic [2:0] bypass_port(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h4;
    case (addr)
      pio_pkg::ADDR_PORT0_BYPASS: sel = 3'h0;
      pio_pkg::ADDR_PORT1_BYPASS: sel = 3'h1;
      pio_pkg::ADDR_PORT2_BYPASS: sel = 3'h2;
      pio_pkg::ADDR_PORT3_BYPASS: sel = 3'h3;
      default: sel = 3'h4;
    endcase
    return sel;
  endfunction

  function automatic logic [2:0] analog_port(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h4;
    case (addr)
      pio_pkg::ADDR_PORT0_ANALOG: sel = 3'h0;
      pio_pkg::ADDR_PORT1_ANALOG: sel = 3'h1;
      pio_pkg::ADDR_PORT2_ANALOG: sel = 3'h2;
      pio_pkg::ADDR_PORT3_ANALOG: sel = 3'h3;
      default: sel = 3'h4;
    endcase
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pio_pkg::pio_state_t state_reg;
  pio_pkg::pio_state_t state_next;

  logic [3:0][7:0] port_mask;
  logic [3:0][7:0] pin_read;
  logic [7:0] bit_byte_addr;
  logic [2:0] bit_sel;
  logic [2:0] byte_latch_sel;
  logic [2:0] bit_latch_sel;
  logic [2:0] drive_sel;
  logic [2:0] bypass_sel;
  logic [2:0] analog_sel;

  assign port_mask[0] = 8'hFF;
  assign port_mask[1] = 8'hFF;
  assign port_mask[2] = 8'hFF;
  assign port_mask[3] = PORT3_MASK; // RULE19

  assign bit_byte_addr = {sfr_req.addr[7:3], 3'b000};
  assign bit_sel = sfr_req.addr[2:0];
  assign byte_latch_sel = latch_port(sfr_req.addr);
  assign bit_latch_sel = latch_port(bit_byte_addr);
  assign drive_sel = drive_port(sfr_req.addr);
  assign bypass_sel = bypass_port(sfr_req.addr);
  assign analog_sel = analog_port(sfr_req.addr);

  // ----------------------------------------------------------------
  // pin read path
  // ----------------------------------------------------------------
  generate
    for (genvar p = 0; p < pio_pkg::NUM_PORTS; p++) begin : g_read
      // analog pins read zero, digital pins read the synced level
      assign pin_read[p] = state_reg.sync2[p] &
        state_reg.input_mode[p] & port_mask[p]; // RULE10 RULE6
    end
  endgenerate

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = pin_in;
    state_next.sync2 = state_reg.sync1;

    // writes
    if (sfr_req.wr && sfr_req.bit_mode) begin
      if (sfr_req.addr[7] && bit_latch_sel < 3'h4) begin
        // only the addressed latch bit changes
        state_next.latch[bit_latch_sel[1:0]][bit_sel] =
          sfr_req.wdata[0]; // RULE4 RULE23
      end
    end else if (sfr_req.wr) begin
      if (byte_latch_sel < 3'h4) begin
        state_next.latch[byte_latch_sel[1:0]] = sfr_req.wdata; // RULE4 RULE5
      end
      if (drive_sel < 3'h4) begin
        state_next.drive_type[drive_sel[1:0]] = sfr_req.wdata; // RULE13
      end
      if (bypass_sel < 3'h4) begin
        state_next.bypass[bypass_sel[1:0]] = sfr_req.wdata; // RULE16
      end
      if (analog_sel < 3'h4) begin
        state_next.input_mode[analog_sel[1:0]] = sfr_req.wdata; // RULE12
      end
      if (sfr_req.addr == pio_pkg::ADDR_ROUTING_THIRD) begin
        // reserved upper bits are not stored
        state_next.second_uart_route_en =
          sfr_req.wdata[pio_pkg::UART_ROUTE_BIT]; // RULE1 RULE2
      end
    end

    // reads
    if (sfr_req.rd && sfr_req.bit_mode) begin
      state_next.rdata = pio_pkg::READ_NONE;
      if (sfr_req.addr[7] && bit_latch_sel < 3'h4) begin
        if (sfr_req.rmw) begin
          state_next.rdata[0] =
            state_reg.latch[bit_latch_sel[1:0]][bit_sel]; // RULE7
        end else begin
          state_next.rdata[0] =
            pin_read[bit_latch_sel[1:0]][bit_sel]; // RULE6
        end
      end
    end else if (sfr_req.rd) begin
      state_next.rdata = pio_pkg::READ_NONE;
      if (byte_latch_sel < 3'h4) begin
        if (sfr_req.rmw) begin
          state_next.rdata = state_reg.latch[byte_latch_sel[1:0]]; // RULE7
        end else begin
          state_next.rdata = pin_read[byte_latch_sel[1:0]]; // RULE6
        end
      end else if (drive_sel < 3'h4) begin
        state_next.rdata = state_reg.drive_type[drive_sel[1:0]];
      end else if (bypass_sel < 3'h4) begin
        state_next.rdata = state_reg.bypass[bypass_sel[1:0]];
      end else if (analog_sel < 3'h4) begin
        state_next.rdata = state_reg.input_mode[analog_sel[1:0]];
      end else if (sfr_req.addr == pio_pkg::ADDR_ROUTING_THIRD) begin
        state_next.rdata[pio_pkg::UART_ROUTE_BIT] =
          state_reg.second_uart_route_en;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= RESET_STATE; // RULE12 RULE13 RULE16 RULE24
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  generate
    for (genvar p = 0; p < pio_pkg::NUM_PORTS; p++) begin : g_pin
      logic [7:0] digital;
      logic [7:0] drive_en;
      logic [7:0] data;
      logic [7:0] push_pull;
      logic [7:0] wants_drive;
      logic [7:0] oe;

      // analog pins lose driver, receiver and pull-up
      assign digital = state_reg.input_mode[p] & port_mask[p]; // RULE11
      // drivers only while crossbar enabled
      assign drive_en = {8{crossbar_global_en}} & digital; // RULE20 RULE8
      // crossbar-assigned pins carry the peripheral, others the latch
      assign data = (xbar_pin[p].assigned & xbar_pin[p].out) |
        (~xbar_pin[p].assigned & state_reg.latch[p]); // RULE3 RULE8 RULE18
      // drive type ignored on analog pins, smbus forced open-drain
      assign push_pull = state_reg.drive_type[p] & digital &
        ~xbar_pin[p].open_drain; // RULE14 RULE15
      assign wants_drive = ~xbar_pin[p].assigned | xbar_pin[p].oe;
      // low driven when drive_en and wants_drive, high only when also push-pull
      assign oe = drive_en & wants_drive & (~data | push_pull); // RULE9

      assign pin_ctl[p].out = data & digital; // RULE9
      assign pin_ctl[p].oe = oe;
      assign pin_ctl[p].pullup_en = digital & ~push_pull &
        {8{~weak_pullup_disable}} & ~(oe & ~data); // RULE21 RULE22
      assign pin_ctl[p].rx_en = digital; // RULE11
      assign pin_level[p] = pin_read[p];
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs to crossbar and bus
  // ----------------------------------------------------------------
  assign crossbar_bypass_mask = state_reg.bypass; // RULE16 RULE17
  assign second_uart_route_en = state_reg.second_uart_route_en; // RULE2
  assign sfr_rdata = state_reg.rdata;

endmodule // pio_port_block

// >>> sim/pio_pin_model.sv
// ----------------------------------------------------------------
// pad model for all four ports
// ----------------------------------------------------------------
module pio_pin_model (
  // clock
  input wire logic ref_clk,
  // pad controls and levels
  input wire pio_pkg::pio_pin_ctl_t [3:0] pin_ctl,
  output logic [3:0][7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flt = 8'h5A;
  // undriven pads with no pull-up wander every cycle
  always @(posedge ref_clk) flt <= ~flt;
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pin_in[p] = (pin_ctl[p].oe & pin_ctl[p].out) |
        (~pin_ctl[p].oe & (pin_ctl[p].pullup_en | flt));
    end
  end
endmodule // pio_pin_model

// >>> sim/pio_port_block_sva.sv
// ----------------------------------------------------------------
// port block checker
// ----------------------------------------------------------------
module pio_port_block_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register bus
  input wire pio_pkg::pio_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  // crossbar side
  input wire logic crossbar_global_en,
  input wire logic weak_pullup_disable,
  input wire pio_pkg::pio_xbar_pin_t [3:0] xbar_pin,
  input wire logic [3:0][7:0] crossbar_bypass_mask,
  input wire logic second_uart_route_en,
  // pins
  input wire logic [3:0][7:0] pin_in,
  input wire pio_pkg::pio_pin_ctl_t [3:0] pin_ctl,
  input wire logic [3:0][7:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  xbar_off_a: assert property (!crossbar_global_en |->
    (pin_ctl[0].oe | pin_ctl[1].oe | pin_ctl[2].oe | pin_ctl[3].oe) == 8'h00)
    else $error("driver on while crossbar off");
  analog_quiet_a: assert property (
    ((pin_ctl[1].oe | pin_ctl[1].pullup_en) & ~pin_ctl[1].rx_en) == 8'h00)
    else $error("analog pin not quiet");
  analog_read_a: assert property (
    (pin_level[1] & ~pin_ctl[1].rx_en) == 8'h00)
    else $error("analog pin reads one");
  pullup_low_a: assert property (
    (pin_ctl[1].pullup_en & pin_ctl[1].oe & ~pin_ctl[1].out) == 8'h00)
    else $error("pull-up on low driver");
  smbus_od_a: assert property (
    (xbar_pin[0].open_drain & pin_ctl[0].oe & pin_ctl[0].out) == 8'h00)
    else $error("smbus pin driven high");
  latch_read_a: assert property (
    sfr_req.wr && sfr_req.addr == 8'h90 && !sfr_req.bit_mode ##1
    sfr_req.rd && sfr_req.rmw && !sfr_req.wr && !sfr_req.bit_mode &&
    sfr_req.addr == 8'h90 |=> sfr_rdata == $past(sfr_req.wdata, 2))
    else $error("rmw read not latch");
  route_wr_a: assert property (
    sfr_req.wr && !sfr_req.bit_mode && sfr_req.addr == 8'hE3 |=>
    second_uart_route_en == $past(sfr_req.wdata[0]))
    else $error("route bit not stored");
  reset_val_a: assert property ($rose(rst_b) |->
    pin_ctl[1].rx_en == 8'hFF && crossbar_bypass_mask == '0 &&
    !second_uart_route_en) else $error("bad reset state");
  cover property (sfr_req.wr && sfr_req.bit_mode);
  cover property (!crossbar_global_en);
  cover property (|xbar_pin[0].open_drain);
endmodule // pio_port_block_sva

bind pio_port_block pio_port_block_sva i_sva (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata),
  .crossbar_global_en(crossbar_global_en),
  .weak_pullup_disable(weak_pullup_disable),
  .xbar_pin(xbar_pin),
  .crossbar_bypass_mask(crossbar_bypass_mask),
  .second_uart_route_en(second_uart_route_en),
  .pin_in(pin_in),
  .pin_ctl(pin_ctl),
  .pin_level(pin_level)
);

// >>> sim/pio_port_block_test.sv
// ----------------------------------------------------------------
// port block bench
// ----------------------------------------------------------------
module pio_port_block_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  pio_pkg::pio_sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic crossbar_global_en = 1'b0;
  logic weak_pullup_disable = 1'b0;
  pio_pkg::pio_xbar_pin_t [3:0] xbar_pin = '0;
  logic [3:0][7:0] crossbar_bypass_mask;
  logic second_uart_route_en;
  logic [3:0][7:0] pin_in;
  pio_pkg::pio_pin_ctl_t [3:0] pin_ctl;
  logic [3:0][7:0] pin_level;
  pio_pkg::pio_pin_ctl_t [3:0] small_ctl;
  int n_mismatch = 0;
  int n_tests = 0;
  always #20 ref_clk = ~ref_clk;
  pio_port_block i_dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .crossbar_global_en(crossbar_global_en),
    .weak_pullup_disable(weak_pullup_disable),
    .xbar_pin(xbar_pin),
    .crossbar_bypass_mask(crossbar_bypass_mask),
    .second_uart_route_en(second_uart_route_en),
    .pin_in(pin_in),
    .pin_ctl(pin_ctl),
    .pin_level(pin_level)
  );
  // small package variant, port 3 cut to bit 0
  pio_port_block #(
    .PORT3_FULL(1'b0)
  ) i_dut_small (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sfr_req(sfr_req),
    .sfr_rdata(),
    .crossbar_global_en(crossbar_global_en),
    .weak_pullup_disable(weak_pullup_disable),
    .xbar_pin(xbar_pin),
    .crossbar_bypass_mask(),
    .second_uart_route_en(),
    .pin_in(pin_in),
    .pin_ctl(small_ctl),
    .pin_level()
  );
  pio_pin_model i_pads (
    .ref_clk(ref_clk),
    .pin_ctl(pin_ctl),
    .pin_in(pin_in)
  );
  task automatic chk(input logic [7:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic w(input logic [7:0] a, d, input logic bm = 1'b0);
    sfr_req = '{a, d, 1'b1, 1'b0, bm, 1'b0};
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e, input logic m = 1'b1,
                    input logic bm = 1'b0);
    sfr_req = '{a, 8'h00, 1'b0, 1'b1, bm, m};
    @(posedge ref_clk);
    #1;
    chk(sfr_rdata, e);
  endtask
  task automatic settle;
    sfr_req = '0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic s_reset;
    logic [7:0] ad [9] = '{8'h80, 8'h90, 8'hA0, 8'hB0, 8'hA5, 8'hD4,
                           8'hE3, 8'hF1, 8'hC0};
    logic [7:0] ex [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00,
                           8'h00, 8'hFF, 8'h00};
    w(8'hC0, 8'h5A);
    foreach (ad[i]) rd(ad[i], ex[i]);
  endtask
  task automatic s_latch;
    crossbar_global_en = 1'b1;
    w(8'h90, 8'h5A);
    rd(8'h90, 8'h5A);
    w(8'h92, 8'h01, 1'b1);
    w(8'h91, 8'h00, 1'b1);
    rd(8'h90, 8'h5C);
    rd(8'h92, 8'h01, 1'b1, 1'b1);
    chk(pin_ctl[1].oe, 8'hA3);
    chk(pin_ctl[1].pullup_en, 8'h5C);
    settle;
    rd(8'h90, 8'h5C, 1'b0);
    w(8'hA5, 8'hFF);
    chk(pin_ctl[1].oe, 8'hFF);
  endtask
  task automatic s_analog;
    w(8'hF2, 8'hF0);
    chk(pin_ctl[1].oe, 8'hF0);
    chk(pin_ctl[1].rx_en, 8'hF0);
    settle;
    rd(8'h90, 8'h50, 1'b0);
    chk(pin_level[1], 8'h50);
    rd(8'h90, 8'h5C);
    w(8'hF2, 8'hFF);
  endtask
  task automatic s_xbar;
    xbar_pin[0] = '{8'h03, 8'h02, 8'h03, 8'h03};
    w(8'hA4, 8'hFF);
    chk(pin_ctl[0].oe, 8'hFD);
    chk(pin_ctl[0].out, 8'hFE);
    settle;
    rd(8'h80, 8'hFE, 1'b0);
    crossbar_global_en = 1'b0;
    @(posedge ref_clk);
    #1;
    chk(pin_ctl[0].oe | pin_ctl[1].oe | pin_ctl[3].oe, 8'h00);
    crossbar_global_en = 1'b1;
    xbar_pin = '0;
  endtask
  task automatic s_route;
    w(8'hE3, 8'h01);
    chk({7'h00, second_uart_route_en}, 8'h01);
    rd(8'hE3, 8'h01, 1'b0);
    w(8'hE3, 8'h00);
    chk({7'h00, second_uart_route_en}, 8'h00);
    w(8'hD5, 8'hA5);
    chk(crossbar_bypass_mask[1], 8'hA5);
  endtask
  task automatic s_port3;
    w(8'hB0, 8'h00);
    chk(pin_ctl[3].oe, 8'hFF);
    chk(small_ctl[3].oe, 8'h01);
    w(8'hF4, 8'hFE);
    chk(pin_ctl[3].oe, 8'hFE);
    chk(small_ctl[3].oe, 8'h00);
    weak_pullup_disable = 1'b1;
    settle;
    chk(pin_ctl[2].pullup_en, 8'h00);
  endtask
  task automatic s_rerst;
    rst_b = 1'b0;
    @(posedge ref_clk);
    #1 rst_b = 1'b1;
    @(posedge ref_clk);
    #1;
    rd(8'hB0, 8'hFF);
    rd(8'hF4, 8'hFF);
    chk(pin_ctl[3].oe, 8'h00);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    @(posedge ref_clk);
    #1;
    s_reset;
    s_latch;
    s_analog;
    s_xbar;
    s_route;
    s_port3;
    s_rerst;
    final_report;
  end
endmodule // pio_port_block_test
